/* core/pxs_meas.sv */
`timescale 1ns/10ps
`default_nettype none
module pxs_meas
	import pxs_pkg::*;
#(
	parameter int HALF_T_CYC = HALF_T_CYC_DEF
) (
	input wire logic ref_clk, // System clock
	input wire logic rst, // Async reset, high
	input wire pxs_cfg_type cfg, // Live configuration
	input wire logic [15:0] cancel, // Crosstalk level
	input wire logic [15:0] thr_lo, // Lower threshold
	input wire logic [15:0] thr_hi, // Upper threshold
	input wire logic [15:0] adc_data, // Front-end count
	output logic emitter_on, // Emitter window
	output logic force_taken, // Forced run started
	output pxs_meas_type meas // Result and events
);
	typedef enum logic [1:0] {
		M_IDLE = 2'h1,
		M_INTEG = 2'h2
	} pxs_meas_state_type;
	pxs_meas_state_type state_q;
	logic [23:0] win_cyc;
	logic [23:0] period_cyc;
	logic [23:0] timer_q;
	logic [15:0] val;
	logic start, sample, above, below, app_now, dep_now;
	logic [2:0] hi_cnt_q, lo_cnt_q;
	logic fast_q, near_q, app_q, dep_q, done_q;
	logic [15:0] result_q;

	assign win_cyc = 24'(it_halves(cfg.it)) * 24'(HALF_T_CYC);
	assign period_cyc = win_cyc * (24'(DUTY_BASE) << cfg.duty);
	assign start = state_q == M_IDLE && !cfg.shutdown &&
		(cfg.force_mode ? cfg.force_go : (timer_q == 24'h0 || fast_q));
	assign force_taken = start && cfg.force_mode;
	assign sample = state_q == M_INTEG && timer_q == 24'h0;

	always_comb begin
		val = adc_data > cancel ? adc_data - cancel : 16'h0000;
		if (!cfg.res16 && val > FULL_SCALE_12) begin
			val = FULL_SCALE_12;
		end
	end
	assign above = val > thr_hi;
	assign below = val < thr_lo;
	assign app_now = sample && !near_q && above &&
		hi_cnt_q == {1'b0, cfg.pers};
	assign dep_now = sample && near_q && below &&
		lo_cnt_q == {1'b0, cfg.pers};

	// ----------------------------------------
	// Measurement pacing
	// ----------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_q <= M_IDLE;
			timer_q <= 24'h0;
			emitter_on <= 1'b0;
		end else begin
			case (state_q)
				M_IDLE: begin
					if (start) begin
						state_q <= M_INTEG;
						timer_q <= win_cyc - 24'h1;
						emitter_on <= 1'b1;
					end else if (timer_q != 24'h0) begin
						timer_q <= timer_q - 24'h1;
					end
				end
				M_INTEG: begin
					if (timer_q == 24'h0) begin
						state_q <= M_IDLE;
						emitter_on <= 1'b0;
						timer_q <= period_cyc - win_cyc - 24'h1;
					end else begin
						timer_q <= timer_q - 24'h1;
					end
				end
				default: begin
					state_q <= M_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Persistence and hysteresis
	// ----------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			hi_cnt_q <= 3'h0;
			lo_cnt_q <= 3'h0;
			near_q <= 1'b0;
			fast_q <= 1'b0;
			app_q <= 1'b0;
			dep_q <= 1'b0;
			done_q <= 1'b0;
			result_q <= 16'h0000;
		end else begin
			app_q <= app_now;
			dep_q <= dep_now;
			done_q <= sample;
			if (start) begin
				fast_q <= 1'b0;
			end
			if (sample) begin
				result_q <= val;
				hi_cnt_q <= above ? hi_cnt_q + 3'h1 : 3'h0;
				lo_cnt_q <= below ? lo_cnt_q + 3'h1 : 3'h0;
				if (app_now) begin
					near_q <= 1'b1;
				end
				if (dep_now) begin
					near_q <= 1'b0;
				end
				fast_q <= cfg.smart && !app_now && !dep_now &&
					(near_q ? below : above);
			end
		end
	end
	assign meas = '{result: result_q, approach: app_q, depart: dep_q,
		near: near_q, done: done_q};

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	res_clamp_a: assert property (sample && !cfg.res16 |=>
		meas.result <= FULL_SCALE_12) else $error("12-bit overflow");
	cancel_floor_a: assert property (sample && adc_data <= cancel |=>
		meas.result == 16'h0000) else $error("cancel not applied");
	pers_hold_a: assert property (sample && !near_q &&
		hi_cnt_q < {1'b0, cfg.pers} |=> !meas.approach)
		else $error("early approach event");
	fast_retry_a: assert property (sample && cfg.smart && !near_q &&
		above && !app_now && !cfg.shutdown && !cfg.force_mode
		|-> ##2 state_q == M_INTEG) else $error("no fast retry");
	shutdown_hold_a: assert property (cfg.shutdown &&
		state_q == M_IDLE |=> state_q == M_IDLE && !emitter_on)
		else $error("measured in shutdown");
endmodule
`default_nettype wire

/* core/pxs_pkg.sv */
// Operation
// - Answer only target address 0x41
// - Word access: command, low byte, high
// - Read uses repeated start; host NACKs high
// - Acknowledge address, command and written bytes
// - Result in 12-bit or 16-bit full scale
// - Reading flag register clears pending interrupt
// - Interrupt above high or below low threshold
// - Raise only after persistence count met
// - Flag register records which threshold fired
// - Subtract 16-bit crosstalk cancellation level
// - Logic mode gives plain near level
// - Smart persistence shortens response time
// - Duty ratio and integration time pace measurement
// - Code 3 low byte timing, reset 0x01
// - Code 3 high byte width, trigger
// - Code 4 feature and current bytes, reset zero
// - Bit 1 approach, bit 0 depart
// - Trigger field: off, approach, depart, both
// - Persistence field selects 1 to 4
// - Width bit: clear 12-bit, set 16-bit
`default_nettype none
package pxs_pkg;
	localparam logic [6:0] DEV_ADDR = 7'h41;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [7:0] CMD_RSVD0 = 8'h00;
	localparam logic [7:0] CMD_CONF12 = 8'h03;
	localparam logic [7:0] CMD_CONF3MS = 8'h04;
	localparam logic [7:0] CMD_CANCEL = 8'h05;
	localparam logic [7:0] CMD_THR_LO = 8'h06;
	localparam logic [7:0] CMD_THR_HI = 8'h07;
	localparam logic [7:0] CMD_DATA1 = 8'h08;
	localparam logic [7:0] CMD_FLAGS = 8'h0d;
	localparam logic [7:0] CMD_ID = 8'h0e;
	localparam logic [7:0] RST_RSVD0 = 8'h01;
	localparam logic [7:0] RST_CONF1 = 8'h01;
	localparam logic [7:0] RST_CONF2 = 8'h00;
	localparam logic [7:0] RST_CONF3 = 8'h00;
	localparam logic [7:0] RST_MS = 8'h00;
	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic [7:0] MS_WR_MASK = 8'h7f;
	// Arbitrary identification value
	localparam logic [7:0] DEV_ID_LOW = 8'h5a;
	localparam logic [7:0] DEV_ID_HIGH = 8'h00;
	localparam int CONF1_DUTY_LSB = 6;
	localparam int CONF1_PERS_LSB = 4;
	localparam int CONF1_IT_LSB = 1;
	localparam int CONF1_SD_BIT = 0;
	localparam int CONF2_RES_BIT = 3;
	localparam int CONF2_TRIG_LSB = 0;
	localparam int CONF3_LOWI_BIT = 7;
	localparam int CONF3_SEL_LSB = 5;
	localparam int CONF3_SMART_BIT = 4;
	localparam int CONF3_FORCE_BIT = 3;
	localparam int CONF3_TRIG_BIT = 2;
	localparam int CONF3_LOGIC_BIT = 1;
	localparam int MS_CUR_LSB = 0;
	localparam int FLAG_APPROACH_BIT = 1;
	localparam int FLAG_DEPART_BIT = 0;
	localparam logic [1:0] TRIG_APPROACH = 2'h1;
	localparam logic [1:0] TRIG_DEPART = 2'h2;
	localparam logic [15:0] FULL_SCALE_12 = 16'h0fff;
	localparam int CLK_PERIOD_NS = 20;
	localparam int HALF_T_NS = 500;
	localparam int HALF_T_CYC_DEF = (HALF_T_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int DUTY_BASE = 40;
	typedef struct packed {
		logic [1:0] duty;
		logic [1:0] pers;
		logic [2:0] it;
		logic shutdown;
		logic res16;
		logic [1:0] trig_sel;
		logic smart;
		logic force_mode;
		logic force_go;
		logic logic_mode;
	} pxs_cfg_type;
	typedef struct packed {
		logic [15:0] result;
		logic approach;
		logic depart;
		logic near;
		logic done;
	} pxs_meas_type;
	// Integration window in half units of T
	function automatic logic [4:0] it_halves(input logic [2:0] code);
		case (code)
			3'h0: it_halves = 5'h02;
			3'h1: it_halves = 5'h03;
			3'h2: it_halves = 5'h04;
			3'h3: it_halves = 5'h05;
			3'h4: it_halves = 5'h06;
			3'h5: it_halves = 5'h07;
			3'h6: it_halves = 5'h08;
			default: it_halves = 5'h10;
		endcase
	endfunction
endpackage
`default_nettype wire

/* core/pxs_top.sv */
`timescale 1ns/10ps
`default_nettype none
module pxs_top
	import pxs_pkg::*;
#(
	parameter int HALF_T_CYC = HALF_T_CYC_DEF
) (
	input wire logic ref_clk, // 50 MHz clock
	input wire logic rst, // Async reset, high
	input wire logic scl_in, // Bus clock pin
	input wire logic sda_in, // Bus data pin level
	output logic sda_out, // Data drive level
	output logic sda_oe_n, // Low while pulling data
	input wire logic [15:0] adc_data, // Front-end count
	output logic int_n, // Interrupt or near level
	output logic emitter_on, // Emitter pulse window
	output logic [1:0] emitter_sel, // Emitter select
	output logic [2:0] emitter_current, // Current code
	output logic emitter_low_current // Tenth current
);
	typedef enum logic [8:0] {
		S_IDLE = 9'h001,
		S_ADDR = 9'h002,
		S_ACK_ADDR = 9'h004,
		S_CMD = 9'h008,
		S_ACK_CMD = 9'h010,
		S_WDATA = 9'h020,
		S_ACK_WR = 9'h040,
		S_RDATA = 9'h080,
		S_ACK_RD = 9'h100
	} pxs_i2c_state_type;

	pxs_i2c_state_type state_q;
	logic scl_s1_q, scl_s2_q, scl_s3_q;
	logic sda_s1_q, sda_s2_q, sda_s3_q;
	logic scl_rise, scl_fall, start_det, stop_det;
	logic [3:0] bit_cnt_q;
	logic [7:0] shift_q, tx_q, cmd_q, low_buf_q;
	logic rw_q, byte_hi_q, mack_q, sda_oe_n_q;
	logic wr_word, flag_read, byte_full;
	logic [15:0] word, rd_word;
	logic [7:0] conf1_q, conf2_q, conf3_q, ms_q;
	logic [15:0] cancel_q, thr_lo_q, thr_hi_q;
	logic [1:0] flags_q;
	logic int_n_q, set_app, set_dep;
	logic [1:0] emit_idx;
	logic [15:0] result_q [3];
	pxs_cfg_type cfg;
	pxs_meas_type meas;
	logic force_taken;

	// ----------------------------------------
	// Pin synchronisers and bus events
	// ----------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			{scl_s3_q, scl_s2_q, scl_s1_q} <= 3'h7;
			{sda_s3_q, sda_s2_q, sda_s1_q} <= 3'h7;
		end else begin
			{scl_s3_q, scl_s2_q, scl_s1_q} <= {scl_s2_q, scl_s1_q, scl_in};
			{sda_s3_q, sda_s2_q, sda_s1_q} <= {sda_s2_q, sda_s1_q, sda_in};
		end
	end

	assign scl_rise = scl_s2_q && !scl_s3_q;
	assign scl_fall = !scl_s2_q && scl_s3_q;
	// Data moves while clock stays high
	assign start_det = scl_s2_q && scl_s3_q && sda_s3_q && !sda_s2_q;
	assign stop_det = scl_s2_q && scl_s3_q && !sda_s3_q && sda_s2_q;
	assign byte_full = bit_cnt_q == BYTE_BITS;

	// ----------------------------------------
	// Target protocol engine
	// ----------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_q <= S_IDLE;
			bit_cnt_q <= 4'h0;
			shift_q <= 8'h00;
			tx_q <= 8'hff;
			rw_q <= 1'b0;
			byte_hi_q <= 1'b0;
			mack_q <= 1'b0;
			sda_oe_n_q <= 1'b1;
		end else if (stop_det) begin
			state_q <= S_IDLE;
			sda_oe_n_q <= 1'b1;
		end else if (start_det) begin
			state_q <= S_ADDR;
			bit_cnt_q <= 4'h0;
			sda_oe_n_q <= 1'b1;
		end else if (scl_rise) begin
			if (state_q == S_ADDR || state_q == S_CMD ||
				state_q == S_WDATA) begin
				shift_q <= {shift_q[6:0], sda_s2_q};
				bit_cnt_q <= bit_cnt_q + 4'h1;
			end
			if (state_q == S_ACK_RD) begin
				mack_q <= !sda_s2_q;
			end
		end else if (scl_fall) begin
			case (state_q)
				S_ADDR: begin
					if (byte_full) begin
						if (shift_q[7:1] == DEV_ADDR) begin
							state_q <= S_ACK_ADDR;
							sda_oe_n_q <= 1'b0;
							rw_q <= shift_q[0];
						end else begin
							state_q <= S_IDLE;
						end
					end
				end
				S_ACK_ADDR: begin
					byte_hi_q <= 1'b0;
					if (rw_q) begin
						state_q <= S_RDATA;
						sda_oe_n_q <= rd_word[7];
						tx_q <= {rd_word[6:0], 1'b1};
						bit_cnt_q <= 4'h1;
					end else begin
						state_q <= S_CMD;
						sda_oe_n_q <= 1'b1;
						bit_cnt_q <= 4'h0;
					end
				end
				S_CMD, S_WDATA: begin
					if (byte_full) begin
						state_q <= state_q == S_CMD ? S_ACK_CMD : S_ACK_WR;
						sda_oe_n_q <= 1'b0;
					end
				end
				S_ACK_CMD, S_ACK_WR: begin
					state_q <= S_WDATA;
					sda_oe_n_q <= 1'b1;
					bit_cnt_q <= 4'h0;
					byte_hi_q <= state_q == S_ACK_WR && !byte_hi_q;
				end
				S_RDATA: begin
					if (byte_full) begin
						state_q <= S_ACK_RD;
						sda_oe_n_q <= 1'b1;
					end else begin
						sda_oe_n_q <= tx_q[7];
						tx_q <= {tx_q[6:0], 1'b1};
						bit_cnt_q <= bit_cnt_q + 4'h1;
					end
				end
				S_ACK_RD: begin
					if (mack_q && !byte_hi_q) begin
						state_q <= S_RDATA;
						byte_hi_q <= 1'b1;
						sda_oe_n_q <= rd_word[15];
						tx_q <= {rd_word[14:8], 1'b1};
						bit_cnt_q <= 4'h1;
					end else begin
						state_q <= S_IDLE;
						sda_oe_n_q <= 1'b1;
					end
				end
				default: begin
					state_q <= S_IDLE;
					sda_oe_n_q <= 1'b1;
				end
			endcase
		end
	end
	assign sda_out = 1'b0;
	assign sda_oe_n = sda_oe_n_q;

	// ----------------------------------------
	// Command code and low byte capture
	// ----------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cmd_q <= CMD_RSVD0;
			low_buf_q <= 8'h00;
		end else begin
			if (scl_fall && state_q == S_CMD && byte_full) begin
				cmd_q <= shift_q;
			end
			if (scl_fall && state_q == S_WDATA && byte_full &&
				!byte_hi_q) begin
				low_buf_q <= shift_q;
			end
		end
	end
	assign wr_word = scl_fall && state_q == S_WDATA && byte_full &&
		byte_hi_q;
	assign word = {shift_q, low_buf_q};

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			conf1_q <= RST_CONF1;
			conf2_q <= RST_CONF2;
			conf3_q <= RST_CONF3;
			ms_q <= RST_MS;
			cancel_q <= RST_WORD;
			thr_lo_q <= RST_WORD;
			thr_hi_q <= RST_WORD;
		end else begin
			if (wr_word) begin
				case (cmd_q)
					CMD_CONF12: begin
						conf1_q <= word[7:0];
						conf2_q <= word[15:8];
					end
					CMD_CONF3MS: begin
						conf3_q <= word[7:0];
						ms_q <= word[15:8] & MS_WR_MASK;
					end
					CMD_CANCEL: begin
						cancel_q <= word;
					end
					CMD_THR_LO: begin
						thr_lo_q <= word;
					end
					CMD_THR_HI: begin
						thr_hi_q <= word;
					end
					default: begin
					end
				endcase
			end
			// One-shot request returns to zero once taken
			if (force_taken) begin
				conf3_q[CONF3_TRIG_BIT] <= 1'b0;
			end
		end
	end

	assign cfg = '{
		duty: conf1_q[CONF1_DUTY_LSB +: 2],
		pers: conf1_q[CONF1_PERS_LSB +: 2],
		it: conf1_q[CONF1_IT_LSB +: 3],
		shutdown: conf1_q[CONF1_SD_BIT],
		res16: conf2_q[CONF2_RES_BIT],
		trig_sel: conf2_q[CONF2_TRIG_LSB +: 2],
		smart: conf3_q[CONF3_SMART_BIT],
		force_mode: conf3_q[CONF3_FORCE_BIT],
		force_go: conf3_q[CONF3_TRIG_BIT],
		logic_mode: conf3_q[CONF3_LOGIC_BIT]
	};
	assign emitter_sel = conf3_q[CONF3_SEL_LSB +: 2];
	assign emitter_low_current = conf3_q[CONF3_LOWI_BIT];
	assign emitter_current = ms_q[MS_CUR_LSB +: 3];

	pxs_meas #(
		.HALF_T_CYC(HALF_T_CYC)
	) u_meas (
		.ref_clk(ref_clk),
		.rst(rst),
		.cfg(cfg),
		.cancel(cancel_q),
		.thr_lo(thr_lo_q),
		.thr_hi(thr_hi_q),
		.adc_data(adc_data),
		.emitter_on(emitter_on),
		.force_taken(force_taken),
		.meas(meas)
	);

	// ----------------------------------------
	// Per-emitter result words
	// ----------------------------------------
	assign emit_idx = emitter_sel == 2'h3 ? 2'h2 : emitter_sel;
	for (genvar i = 0; i < 3; i++) begin : g_res
		always_ff @(posedge ref_clk or posedge rst) begin
			if (rst) begin
				result_q[i] <= RST_WORD;
			end else if (meas.done && emit_idx == 2'(i)) begin
				result_q[i] <= meas.result;
			end
		end
	end

	// ----------------------------------------
	// Read data selection
	// ----------------------------------------
	always_comb begin
		case (cmd_q)
			CMD_RSVD0: rd_word = {RST_RSVD0, RST_RSVD0};
			CMD_CONF12: rd_word = {conf2_q, conf1_q};
			CMD_CONF3MS: rd_word = {ms_q, conf3_q};
			CMD_CANCEL: rd_word = cancel_q;
			CMD_THR_LO: rd_word = thr_lo_q;
			CMD_THR_HI: rd_word = thr_hi_q;
			CMD_DATA1: rd_word = result_q[0];
			CMD_DATA1 + 8'h01: rd_word = result_q[1];
			CMD_DATA1 + 8'h02: rd_word = result_q[2];
			CMD_FLAGS: rd_word = {6'h00, flags_q, 8'h00};
			CMD_ID: rd_word = {DEV_ID_HIGH, DEV_ID_LOW};
			default: rd_word = 16'h0000;
		endcase
	end

	// ----------------------------------------
	// Interrupt flags and pin
	// ----------------------------------------
	assign set_app = meas.approach && cfg.trig_sel[0];
	assign set_dep = meas.depart && cfg.trig_sel[1];
	// High byte of the flag word is loaded for sending
	assign flag_read = scl_fall && state_q == S_ACK_RD && mack_q &&
		!byte_hi_q && cmd_q == CMD_FLAGS;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			flags_q <= 2'h0;
			int_n_q <= 1'b1;
		end else begin
			// New event wins over a clearing read
			flags_q[FLAG_APPROACH_BIT] <= set_app ||
				(flags_q[FLAG_APPROACH_BIT] && !flag_read);
			flags_q[FLAG_DEPART_BIT] <= set_dep ||
				(flags_q[FLAG_DEPART_BIT] && !flag_read);
			if (cfg.logic_mode) begin
				int_n_q <= !meas.near;
			end else begin
				int_n_q <= flags_q == 2'h0;
			end
		end
	end
	assign int_n = int_n_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	sequence addr_hit_s;
		scl_fall && state_q == S_ADDR && byte_full &&
			shift_q[7:1] == DEV_ADDR;
	endsequence
	sequence addr_miss_s;
		scl_fall && state_q == S_ADDR && byte_full &&
			shift_q[7:1] != DEV_ADDR;
	endsequence
	sequence wr_byte_s;
		scl_fall && state_q == S_WDATA && byte_full;
	endsequence
	addr_ack_a: assert property (addr_hit_s |=>
		state_q == S_ACK_ADDR && !sda_oe_n) else $error("no address ack");
	addr_ignore_a: assert property (addr_miss_s |=>
		state_q == S_IDLE && sda_oe_n) else $error("foreign address ack");
	data_ack_a: assert property (wr_byte_s |=>
		!sda_oe_n [*2]) else $error("written byte not acked");
	word_commit_a: assert property (wr_word && cmd_q == CMD_THR_HI |=>
		thr_hi_q == $past(word)) else $error("threshold word lost");
	flag_clear_a: assert property (flag_read && !set_app && !set_dep &&
		!cfg.logic_mode |=> flags_q == 2'h0 ##1 int_n)
		else $error("flag read did not clear");
	flag_cause_a: assert property (set_dep |=>
		flags_q[FLAG_DEPART_BIT]) else $error("depart flag missing");
	trig_mask_a: assert property (meas.approach &&
		!cfg.trig_sel[0] && !flags_q[FLAG_APPROACH_BIT] && !flag_read
		|=> !flags_q[FLAG_APPROACH_BIT]) else $error("masked event flagged");
	logic_pin_a: assert property (cfg.logic_mode |=>
		int_n == !$past(meas.near)) else $error("logic level wrong");
	ro_write_a: assert property (wr_word && cmd_q == CMD_FLAGS |=>
		conf1_q == $past(conf1_q)) else $error("read-only write leaked");
endmodule
`default_nettype wire

/* test/pxs_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module pxs_host_model (
	input wire logic clk, // Pacing clock
	input wire logic sda_bus, // Resolved data line
	output logic scl, // Bus clock, idles high
	output logic sda_drv // Host data, 0 pulls low
);
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	// One 160 ns bit, data set just after the fall
	task automatic bit_io(input logic b, output logic s);
		tick(1);
		sda_drv <= b;
		tick(5);
		scl <= 1'b1;
		tick(1);
		s = sda_bus;
		tick(1);
		scl <= 1'b0;
	endtask
	task automatic put_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(d[i], s);
		bit_io(1'b1, s);
		ack = ~s;
	endtask
	task automatic get_byte(input logic nack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, s);
			d[i] = s;
		end
		bit_io(nack, s);
	endtask
	// Repeated start waits out the target's ack release
	task automatic start_cond(input logic rep);
		tick(1);
		if (rep) begin
			sda_drv <= 1'b1;
			tick(5);
			scl <= 1'b1;
			tick(3);
		end
		sda_drv <= 1'b0;
		tick(3);
		scl <= 1'b0;
	endtask
	task automatic stop_cond;
		tick(1);
		sda_drv <= 1'b0;
		tick(3);
		scl <= 1'b1;
		tick(3);
		sda_drv <= 1'b1;
		tick(6);
	endtask
	task automatic wr_word(input logic [6:0] a, input logic [7:0] c,
		input logic [15:0] d, output logic [3:0] ak);
		start_cond(1'b0);
		put_byte({a, 1'b0}, ak[0]);
		put_byte(c, ak[1]);
		put_byte(d[7:0], ak[2]);
		put_byte(d[15:8], ak[3]);
		stop_cond();
	endtask
	task automatic rd_word(input logic [6:0] a, input logic [7:0] c,
		output logic [15:0] d, output logic [3:0] ak);
		start_cond(1'b0);
		put_byte({a, 1'b0}, ak[0]);
		put_byte(c, ak[1]);
		start_cond(1'b1);
		put_byte({a, 1'b1}, ak[2]);
		get_byte(1'b0, d[7:0]);
		get_byte(1'b1, d[15:8]);
		ak[3] = 1'b1;
		stop_cond();
	endtask
endmodule
`default_nettype wire

/* test/pxs_top_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module pxs_top_tb;
	import pxs_pkg::*;
	localparam int HT = 1;
	localparam int PER = 2 * HT * DUTY_BASE;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic [15:0] adc_data = 16'h0000;
	logic scl, sda_drv, sda_out, sda_oe_n, int_n, emitter_on, low_cur;
	logic [1:0] emitter_sel;
	logic [2:0] emitter_current;
	logic [15:0] rd;
	logic [3:0] ak;
	int n_errors = 0;
	int comparisons = 0;
	wire logic sda_bus = sda_drv & (sda_oe_n | sda_out);
	always #10 ref_clk = ~ref_clk;
	pxs_top #(.HALF_T_CYC(HT)) dut_u (.ref_clk(ref_clk), .rst(rst),
		.scl_in(scl), .sda_in(sda_bus), .sda_out(sda_out),
		.sda_oe_n(sda_oe_n), .adc_data(adc_data), .int_n(int_n),
		.emitter_on(emitter_on), .emitter_sel(emitter_sel),
		.emitter_current(emitter_current), .emitter_low_current(low_cur));
	pxs_host_model host_u (.clk(ref_clk), .sda_bus(sda_bus), .scl(scl),
		.sda_drv(sda_drv));
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic end_sim;
		$display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic wr(input logic [7:0] c, input logic [15:0] d);
		host_u.wr_word(DEV_ADDR, c, d, ak);
		check({12'h000, ak}, 16'h000f);
	endtask
	task automatic rdc(input logic [7:0] c, input logic [15:0] exp);
		host_u.rd_word(DEV_ADDR, c, rd, ak);
		check({12'h000, ak}, 16'h000f);
		check(rd, exp);
	endtask
	task automatic wait_int(input logic lvl);
		for (int i = 0; i < 20 * PER && int_n !== lvl; i++)
			@(posedge ref_clk);
		check({15'h0000, int_n}, {15'h0000, lvl});
	endtask
	initial begin
		repeat (60000) @(posedge ref_clk);
		n_errors++;
		end_sim();
	end
	initial begin
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (3) @(posedge ref_clk);
		check({12'h000, sda_out, emitter_on, int_n, sda_oe_n}, 16'h0003);
		host_u.wr_word(7'h40, CMD_CONF12, 16'h0b10, ak);
		check({12'h000, ak}, 16'h0000);
		rdc(CMD_CONF12, 16'h0001);
		rdc(CMD_CONF3MS, 16'h0000);
		wr(CMD_RSVD0, 16'h1234);
		rdc(CMD_RSVD0, 16'h0101);
		wr(CMD_FLAGS, 16'hffff);
		rdc(CMD_FLAGS, 16'h0000);
		wr(CMD_CONF3MS, 16'hffe0);
		rdc(CMD_CONF3MS, 16'h7fe0);
		check({10'h0, low_cur, emitter_sel, emitter_current}, 16'h003f);
		wr(CMD_CONF3MS, 16'h0000);
		wr(CMD_CANCEL, 16'h0010);
		wr(CMD_THR_LO, 16'h0100);
		wr(CMD_THR_HI, 16'h0200);
		rdc(CMD_THR_HI, 16'h0200);
		// Both triggers, 16-bit, two samples needed
		adc_data <= 16'h0300;
		wr(CMD_CONF12, 16'h0b10);
		check({15'h0000, int_n}, 16'h0001);
		wait_int(1'b0);
		rdc(CMD_DATA1, 16'h02f0);
		rdc(CMD_FLAGS, 16'h0200);
		wait_int(1'b1);
		adc_data <= 16'h0050;
		wait_int(1'b0);
		rdc(CMD_FLAGS, 16'h0100);
		wait_int(1'b1);
		// Logic output mode follows the near state only
		wr(CMD_CONF3MS, 16'h0002);
		adc_data <= 16'h0300;
		wait_int(1'b0);
		rdc(CMD_FLAGS, 16'h0200);
		check({15'h0000, int_n}, 16'h0000);
		adc_data <= 16'h0050;
		wait_int(1'b1);
		wr(CMD_CONF3MS, 16'h0000);
		rdc(CMD_FLAGS, 16'h0100);
		wait_int(1'b1);
		// Departure-only trigger ignores an approach
		wr(CMD_CONF12, 16'h0a10);
		adc_data <= 16'h0300;
		repeat (4 * PER) @(posedge ref_clk);
		check({15'h0000, int_n}, 16'h0001);
		rdc(CMD_FLAGS, 16'h0000);
		adc_data <= 16'h0050;
		wait_int(1'b0);
		rdc(CMD_FLAGS, 16'h0100);
		// Approach-only trigger
		wr(CMD_CONF12, 16'h0910);
		adc_data <= 16'h0300;
		wait_int(1'b0);
		rdc(CMD_FLAGS, 16'h0200);
		// Interrupt disabled, 12-bit then 16-bit width
		wr(CMD_CONF12, 16'h0010);
		adc_data <= 16'hffff;
		repeat (4 * PER) @(posedge ref_clk);
		rdc(CMD_DATA1, 16'h0fff);
		check({15'h0000, int_n}, 16'h0001);
		wr(CMD_CONF12, 16'h0810);
		repeat (4 * PER) @(posedge ref_clk);
		rdc(CMD_DATA1, 16'hffef);
		// Smart persistence: four crossings within one off time
		wr(CMD_CONF12, 16'h0b30);
		wr(CMD_CONF3MS, 16'h0010);
		adc_data <= 16'h0050;
		repeat (PER + 24) @(posedge ref_clk);
		check({15'h0000, int_n}, 16'h0000);
		rdc(CMD_FLAGS, 16'h0100);
		adc_data <= 16'h0300;
		repeat (PER + 24) @(posedge ref_clk);
		check({15'h0000, int_n}, 16'h0000);
		rdc(CMD_FLAGS, 16'h0200);
		// Forced mode measures once per trigger write
		wr(CMD_CONF3MS, 16'h0008);
		adc_data <= 16'h0008;
		repeat (2 * PER) @(posedge ref_clk);
		check({15'h0000, emitter_on}, 16'h0000);
		rdc(CMD_DATA1, 16'h02f0);
		wr(CMD_CONF3MS, 16'h000c);
		rdc(CMD_DATA1, 16'h0000);
		rdc(CMD_CONF3MS, 16'h0008);
		end_sim();
	end
endmodule
`default_nettype wire
